//--- logic/bwc_regs.sv
// Operation
// - writable prefetch limit upper, resets zero
// - writable io base upper, resets zero
// - writable io limit upper, resets zero
// - capability pointer reads fixed 40h
// - interrupt pin read-only, 00h, loadable override on downstream ports only
// - bit16 gates poisoned tlp reporting
// - bit17 gates secondary error message forwarding
// - bit18 sends isa alias io upstream
// - bit19 forwards vga memory and io
// - vga io low bits 3b0-3bb, 3c0-3df
// - bit20 selects 10 or 16 bit decode
// - bit22 drives hot reset on ports
// - legacy bits 21,23-31 read zero
// - prefetch limit low bits treated all ones
// - base upper joins lower bits into 64-bit prefetch and 32-bit io bases
`timescale 1ns/1ps
`default_nettype none
module bwc_regs
  import bwc_pkg::*;
#(
  parameter bit UPSTREAM = 1'b0,
  parameter int NUM_DS = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  input wire logic pin_load_i,
  input wire logic [7:0] pin_value_i,
  input wire logic [11:0] pf_base_low_i,
  input wire logic [11:0] pf_limit_low_i,
  input wire logic [3:0] io_base_low_i,
  input wire logic [3:0] io_limit_low_i,
  input wire logic req_valid_i,
  input wire logic req_is_io_i,
  input wire logic [63:0] req_addr_i,
  output logic req_done_o,
  output logic fwd_down_o,
  output logic fwd_up_o,
  input wire logic poison_seen_i,
  output logic poison_report_o,
  input wire logic sec_err_msg_i,
  output logic err_fwd_o,
  output logic [NUM_DS-1:0] port_reset_o
);
  logic [31:0] pf_base_upper, next_pf_base_upper;
  logic [31:0] prefetch_limit_upper, next_prefetch_limit_upper;
  logic [15:0] io_base_upper, next_io_base_upper;
  logic [15:0] io_limit_upper, next_io_limit_upper;
  logic [7:0] interrupt_routing_line, next_interrupt_routing_line;
  logic [7:0] interrupt_pin_select, next_interrupt_pin_select;
  logic parity_error_response, next_parity_error_response;
  logic secondary_error_forward_enable, next_secondary_error_forward_enable;
  logic isa_enable, next_isa_enable;
  logic vga_enable, next_vga_enable;
  logic vga_decode16, next_vga_decode16;
  logic sec_bus_reset, next_sec_bus_reset;
  logic [31:0] next_rdata;
  logic next_rvalid;
  logic next_done, next_down, next_up, next_poison, next_err;
  logic [NUM_DS-1:0] next_port_reset;
  logic [63:0] pf_base, pf_limit;
  logic [31:0] io_base, io_limit;
  logic wr_pf_b, wr_pf_l, wr_io, wr_ib;

  // byte-lane merge of a write into a stored dword
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // inclusive range test shared by the io, prefetch and vga memory windows
  function automatic logic in_range(input logic [63:0] a, input logic [63:0] lo,
                                    input logic [63:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // vga io alias test on the low ten bits, optional full 16-bit match
  function automatic logic vga_io_hit(input logic [63:0] a, input logic dec16);
    logic low_ok, high_ok;
    low_ok = ((a[9:0] >= BWC_VGA_IO_A_LO) && (a[9:0] <= BWC_VGA_IO_A_HI)) ||
             ((a[9:0] >= BWC_VGA_IO_B_LO) && (a[9:0] <= BWC_VGA_IO_B_HI));
    high_ok = (a[63:16] == 48'h0) && (!dec16 || (a[15:10] == 6'h00));
    return low_ok && high_ok;
  endfunction

  // write decode
  assign wr_pf_b = cfg_wr_i && (cfg_addr_i[11:2] == BWC_OFF_PF_BASE_UP[11:2]);
  assign wr_pf_l = cfg_wr_i && (cfg_addr_i[11:2] == BWC_OFF_PF_LIM_UP[11:2]);
  assign wr_io = cfg_wr_i && (cfg_addr_i[11:2] == BWC_OFF_IO_UP[11:2]);
  assign wr_ib = cfg_wr_i && (cfg_addr_i[11:2] == BWC_OFF_INT_BC[11:2]);

  // full window bounds from upper fields and implied low bits
  assign pf_base = {pf_base_upper, pf_base_low_i, BWC_PF_BASE_LOW};
  assign pf_limit = {prefetch_limit_upper, pf_limit_low_i, BWC_PF_LIM_LOW};
  assign io_base = {io_base_upper, io_base_low_i, BWC_IO_BASE_LOW};
  assign io_limit = {io_limit_upper, io_limit_low_i, BWC_IO_LIM_LOW};

  // register next values; the pin override loads only on downstream ports
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    next_pf_base_upper = pf_base_upper;
    next_prefetch_limit_upper = prefetch_limit_upper;
    next_io_base_upper = io_base_upper;
    next_io_limit_upper = io_limit_upper;
    next_interrupt_routing_line = interrupt_routing_line;
    next_interrupt_pin_select = interrupt_pin_select;
    next_parity_error_response = parity_error_response;
    next_secondary_error_forward_enable = secondary_error_forward_enable;
    next_isa_enable = isa_enable;
    next_vga_enable = vga_enable;
    next_vga_decode16 = vga_decode16;
    next_sec_bus_reset = sec_bus_reset;
    if (wr_pf_b) begin
      next_pf_base_upper = lane_merge(pf_base_upper, cfg_wdata_i, cfg_be_i);
    end
    if (wr_pf_l) begin
      next_prefetch_limit_upper = lane_merge(prefetch_limit_upper, cfg_wdata_i, cfg_be_i);
    end
    if (wr_io) begin
      m = lane_merge({io_limit_upper, io_base_upper}, cfg_wdata_i, cfg_be_i);
      next_io_base_upper = m[15:0];
      next_io_limit_upper = m[31:16];
    end
    if (wr_ib) begin
      // only implemented bits are stored; 21, 23-31 have no flop
      if (cfg_be_i[0]) begin
        next_interrupt_routing_line = cfg_wdata_i[7:0];
      end
      if (cfg_be_i[2]) begin
        next_parity_error_response = cfg_wdata_i[BWC_BC_PERR];
        next_secondary_error_forward_enable = cfg_wdata_i[BWC_BC_SERR];
        next_isa_enable = cfg_wdata_i[BWC_BC_ISA];
        next_vga_enable = cfg_wdata_i[BWC_BC_VGA];
        next_vga_decode16 = cfg_wdata_i[BWC_BC_VGA16];
        next_sec_bus_reset = cfg_wdata_i[BWC_BC_SRST];
      end
    end
    if (pin_load_i && !UPSTREAM) begin
      next_interrupt_pin_select = pin_value_i;
    end
  end

  // read mux; unmapped dwords read zero
  always_comb begin
    logic [31:0] bc;
    bc = 32'h0;
    bc[BWC_BC_PERR] = parity_error_response;
    bc[BWC_BC_SERR] = secondary_error_forward_enable;
    bc[BWC_BC_ISA] = isa_enable;
    bc[BWC_BC_VGA] = vga_enable;
    bc[BWC_BC_VGA16] = vga_decode16;
    bc[BWC_BC_SRST] = sec_bus_reset;
    bc[15:0] = {interrupt_pin_select, interrupt_routing_line};
    next_rvalid = cfg_rd_i;
    next_rdata = 32'h0;
    if (cfg_rd_i) begin
      unique case (cfg_addr_i[11:2])
        BWC_OFF_PF_BASE_UP[11:2]: next_rdata = pf_base_upper;
        BWC_OFF_PF_LIM_UP[11:2]: next_rdata = prefetch_limit_upper;
        BWC_OFF_IO_UP[11:2]: next_rdata = {io_limit_upper, io_base_upper};
        BWC_OFF_CAP_PTR[11:2]: next_rdata = {24'h0, BWC_CAP_PTR};
        BWC_OFF_INT_BC[11:2]: next_rdata = bc;
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // forwarding decisions; isa aliases go upstream instead of down unless they also hit vga
  always_comb begin
    logic io_win, isa_alias, vga_hit;
    io_win = in_range(req_addr_i, {32'h0, io_base}, {32'h0, io_limit});
    isa_alias = isa_enable && io_win && (req_addr_i[63:16] == 48'h0) &&
                (req_addr_i[9:8] != 2'b00);
    vga_hit = vga_enable && (req_is_io_i ? vga_io_hit(req_addr_i, vga_decode16) :
              in_range(req_addr_i, BWC_VGA_MEM_LO, BWC_VGA_MEM_HI));
    next_done = req_valid_i;
    next_up = req_valid_i && req_is_io_i && isa_alias && !vga_hit;
    next_down = 1'b0;
    if (req_valid_i) begin
      if (req_is_io_i) begin
        next_down = (io_win && !isa_alias) || vga_hit;
      end else begin
        next_down = in_range(req_addr_i, pf_base, pf_limit) || vga_hit;
      end
    end
    next_poison = poison_seen_i && parity_error_response;
    next_err = sec_err_msg_i && secondary_error_forward_enable;
    // upstream port resets every downstream port, downstream only its own link
    next_port_reset = '0;
    if (UPSTREAM) begin
      next_port_reset = {NUM_DS{sec_bus_reset}};
    end else begin
      next_port_reset[0] = sec_bus_reset;
    end
  end

  // state registers, synchronous reset
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pf_base_upper <= BWC_RST_PF_UP;
      prefetch_limit_upper <= BWC_RST_PF_UP;
      io_base_upper <= BWC_RST_IO_UP;
      io_limit_upper <= BWC_RST_IO_UP;
      interrupt_routing_line <= BWC_RST_INT_LINE;
      interrupt_pin_select <= BWC_RST_INT_PIN;
      parity_error_response <= 1'b0;
      secondary_error_forward_enable <= 1'b0;
      isa_enable <= 1'b0;
      vga_enable <= 1'b0;
      vga_decode16 <= 1'b0;
      sec_bus_reset <= 1'b0;
      cfg_rdata_o <= 32'h0;
      cfg_rvalid_o <= 1'b0;
      req_done_o <= 1'b0;
      fwd_down_o <= 1'b0;
      fwd_up_o <= 1'b0;
      poison_report_o <= 1'b0;
      err_fwd_o <= 1'b0;
      port_reset_o <= '0;
    end else begin
      pf_base_upper <= next_pf_base_upper;
      prefetch_limit_upper <= next_prefetch_limit_upper;
      io_base_upper <= next_io_base_upper;
      io_limit_upper <= next_io_limit_upper;
      interrupt_routing_line <= next_interrupt_routing_line;
      interrupt_pin_select <= next_interrupt_pin_select;
      parity_error_response <= next_parity_error_response;
      secondary_error_forward_enable <= next_secondary_error_forward_enable;
      isa_enable <= next_isa_enable;
      vga_enable <= next_vga_enable;
      vga_decode16 <= next_vga_decode16;
      sec_bus_reset <= next_sec_bus_reset;
      cfg_rdata_o <= next_rdata;
      cfg_rvalid_o <= next_rvalid;
      req_done_o <= next_done;
      fwd_down_o <= next_down;
      fwd_up_o <= next_up;
      poison_report_o <= next_poison;
      err_fwd_o <= next_err;
      port_reset_o <= next_port_reset;
    end
  end

  // checks beside the logic
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_cap_ptr_read: assert property (
    cfg_rd_i && cfg_addr_i[11:2] == BWC_OFF_CAP_PTR[11:2]
    |=> cfg_rdata_o == 32'h0000_0040) else $error("cap pointer not 40h");
  a_bc_zero_bits: assert property (
    cfg_rd_i && cfg_addr_i[11:2] == BWC_OFF_INT_BC[11:2]
    |=> cfg_rdata_o[31:23] == 9'h0 && !cfg_rdata_o[21]) else $error("legacy bits set");
  a_limit_write: assert property (
    cfg_wr_i && cfg_addr_i[11:2] == BWC_OFF_PF_LIM_UP[11:2] && cfg_be_i == 4'hf
    |=> prefetch_limit_upper == $past(cfg_wdata_i)) else $error("limit write lost");
  a_io_write: assert property (
    cfg_wr_i && cfg_addr_i[11:2] == BWC_OFF_IO_UP[11:2] && cfg_be_i == 4'hf
    |=> io_base_upper == $past(cfg_wdata_i[15:0]) &&
    io_limit_upper == $past(cfg_wdata_i[31:16])) else $error("io upper write lost");
  a_pin_readonly: assert property (
    cfg_wr_i && cfg_addr_i[11:2] == BWC_OFF_INT_BC[11:2] && !pin_load_i
    |=> $stable(interrupt_pin_select)) else $error("interrupt pin written");
  a_poison_gate: assert property (
    poison_seen_i && !parity_error_response
    |=> !poison_report_o) else $error("poison reported while off");
  a_poison_on: assert property (
    poison_seen_i && parity_error_response
    |=> poison_report_o) else $error("poison not reported");
  a_err_gate: assert property (
    sec_err_msg_i && secondary_error_forward_enable
    |=> err_fwd_o) else $error("error message not forwarded");
  a_isa_no_both: assert property (
    !(fwd_up_o && fwd_down_o)) else $error("forwarded both ways");
  a_vga_mem_hit: assert property (
    req_valid_i && !req_is_io_i && vga_enable && req_addr_i == BWC_VGA_MEM_LO
    |=> fwd_down_o) else $error("vga memory missed");
  a_vga_io_hit: assert property (
    req_valid_i && req_is_io_i && vga_enable && req_addr_i == 64'h3c0
    |=> fwd_down_o) else $error("vga io missed");
  a_hot_reset: assert property (
    $rose(sec_bus_reset) |=> port_reset_o[0]) else $error("hot reset not driven");
  a_hot_reset_off: assert property (
    $fell(sec_bus_reset) |=> !port_reset_o[0]) else $error("hot reset not released");
  a_pf_window: assert property (
    req_valid_i && !req_is_io_i && !vga_enable &&
    req_addr_i == pf_limit && pf_base <= pf_limit
    |=> fwd_down_o) else $error("limit not inclusive");

  // main scenarios: vga forwarding, isa alias, hot reset pulse, pin override, error forward
  c_vga_fwd: cover property (vga_enable && req_valid_i ##1 fwd_down_o);
  c_isa_up: cover property (fwd_up_o);
  c_hot_reset: cover property (sec_bus_reset [*3] ##1 !sec_bus_reset);
  c_pin_load: cover property (pin_load_i ##1 interrupt_pin_select != BWC_RST_INT_PIN);
  c_err_fwd: cover property (err_fwd_o);
endmodule
`default_nettype wire

//--- logic/bwc_pkg.sv
package bwc_pkg;
  // dword byte addresses in configuration space
  localparam logic [11:0] BWC_OFF_PF_BASE_UP = 12'h028;
  localparam logic [11:0] BWC_OFF_PF_LIM_UP = 12'h02c;
  localparam logic [11:0] BWC_OFF_IO_UP = 12'h030;
  localparam logic [11:0] BWC_OFF_CAP_PTR = 12'h034;
  localparam logic [11:0] BWC_OFF_INT_BC = 12'h03c;
  // reset and fixed values
  localparam logic [31:0] BWC_RST_PF_UP = 32'h0000_0000;
  localparam logic [15:0] BWC_RST_IO_UP = 16'h0000;
  localparam logic [7:0] BWC_CAP_PTR = 8'h40;
  localparam logic [7:0] BWC_RST_INT_LINE = 8'h00;
  localparam logic [7:0] BWC_RST_INT_PIN = 8'h00;
  // bridge control bit positions within the 0x3c dword
  localparam int BWC_BC_PERR = 16;
  localparam int BWC_BC_SERR = 17;
  localparam int BWC_BC_ISA = 18;
  localparam int BWC_BC_VGA = 19;
  localparam int BWC_BC_VGA16 = 20;
  localparam int BWC_BC_SRST = 22;
  // implied low bits of the windows
  localparam logic [19:0] BWC_PF_LIM_LOW = 20'hfffff;
  localparam logic [19:0] BWC_PF_BASE_LOW = 20'h00000;
  localparam logic [11:0] BWC_IO_LIM_LOW = 12'hfff;
  localparam logic [11:0] BWC_IO_BASE_LOW = 12'h000;
  // vga ranges
  localparam logic [63:0] BWC_VGA_MEM_LO = 64'h0000_0000_000a_0000;
  localparam logic [63:0] BWC_VGA_MEM_HI = 64'h0000_0000_000b_ffff;
  localparam logic [9:0] BWC_VGA_IO_A_LO = 10'h3b0;
  localparam logic [9:0] BWC_VGA_IO_A_HI = 10'h3bb;
  localparam logic [9:0] BWC_VGA_IO_B_LO = 10'h3c0;
  localparam logic [9:0] BWC_VGA_IO_B_HI = 10'h3df;
endpackage

//--- test/bwc_host.sv
`timescale 1ns/1ps
`default_nettype none
module bwc_host (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i,
  output logic wr_o,
  output logic rd_o,
  output logic [11:0] addr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o
);
  // released lines show the inverse, so a stale address can never pass for a fresh one
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 12'hfff;
    be_o = 4'h0;
    wdata_o = 32'h0;
  end
  // write strobe held for one edge, the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    be_o <= b;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // answer is registered on the taking edge itself and sampled 1ns after it
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic v);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bwc_pkg::*;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, cfg_wr, cfg_rd, rvalid, pin_load = 1'b0, rv = 1'b0;
  logic rio = 1'b0, done, down, up, poison = 1'b0, serr = 1'b0, prep, efwd;
  logic [11:0] addr, pfb = 12'h001, pfl = 12'h002;
  logic [3:0] be, iob = 4'h1, iol = 4'h2;
  logic [31:0] wdata, rdata;
  logic [7:0] pin_value = 8'h00;
  logic [63:0] raddr = 64'h0;
  logic [1:0] prst;
  logic [20:0] vt [10] = '{21'h0003af, 21'h1003b0, 21'h1003bb, 21'h0003bc, 21'h0003bf,
    21'h1003c0, 21'h1003df, 21'h0003e0, 21'h1043b0, 21'h0103b0};
  int failures = 0, cmp_count = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  bwc_host host (.clk_i(sys_clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(cfg_wr),
    .rd_o(cfg_rd), .addr_o(addr), .be_o(be), .wdata_o(wdata));
  bwc_regs #(.UPSTREAM(1'b0), .NUM_DS(2)) uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_addr_i(addr), .cfg_be_i(be),
    .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .pin_load_i(pin_load),
    .pin_value_i(pin_value), .pf_base_low_i(pfb), .pf_limit_low_i(pfl), .io_base_low_i(iob),
    .io_limit_low_i(iol), .req_valid_i(rv), .req_is_io_i(rio), .req_addr_i(raddr),
    .req_done_o(done), .fwd_down_o(down), .fwd_up_o(up), .poison_seen_i(poison),
    .poison_report_o(prep), .sec_err_msg_i(serr), .err_fwd_o(efwd), .port_reset_o(prst));
  // single place where the run ends
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    host.rd(a, d, v);
    chk({31'h0, v}, 32'h1, "read answer");
    chk(d, exp, "read data");
    // the answer stands one cycle, then the bus reads zero again
    @(posedge sys_clk_i);
    #1;
    chk({31'h0, rvalid}, 32'h0, "read answer dropped");
    chk(rdata, 32'h0, "read data cleared");
  endtask
  // bridge control sits in byte lane 2 only
  task automatic bc(input logic [7:0] v);
    host.wr(BWC_OFF_INT_BC, 4'h4, {8'h00, v, 16'h0000});
  endtask
  task automatic look(input logic io, input logic [63:0] a, input logic dn, input logic u);
    @(posedge sys_clk_i);
    rv <= 1'b1;
    rio <= io;
    raddr <= a;
    @(posedge sys_clk_i);
    rv <= 1'b0;
    raddr <= ~a;
    #1;
    chk({29'h0, done, down, up}, {29'h0, 1'b1, dn, u}, "lookup");
  endtask
  task automatic ev(input logic ep, input logic ee);
    @(posedge sys_clk_i);
    poison <= 1'b1;
    serr <= 1'b1;
    @(posedge sys_clk_i);
    poison <= 1'b0;
    serr <= 1'b0;
    #1;
    chk({30'h0, prep, efwd}, {30'h0, ep, ee}, "event gate");
  endtask
  // hang guard: a run this short never needs more
  initial begin
    #200us;
    failures++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rdchk(BWC_OFF_PF_LIM_UP, BWC_RST_PF_UP);
    rdchk(BWC_OFF_IO_UP, {BWC_RST_IO_UP, BWC_RST_IO_UP});
    rdchk(BWC_OFF_CAP_PTR, {24'h0, BWC_CAP_PTR});
    rdchk(BWC_OFF_INT_BC, {16'h0, BWC_RST_INT_PIN, BWC_RST_INT_LINE});
    rdchk(12'h038, 32'h0);
    $display("test reset values done");
    host.wr(BWC_OFF_PF_LIM_UP, 4'hf, 32'hdead_beef);
    rdchk(BWC_OFF_PF_LIM_UP, 32'hdead_beef);
    host.wr(BWC_OFF_IO_UP, 4'h3, 32'haaaa_5555);
    rdchk(BWC_OFF_IO_UP, 32'h0000_5555);
    host.wr(BWC_OFF_IO_UP, 4'hc, 32'haaaa_1234);
    rdchk(BWC_OFF_IO_UP, 32'haaaa_5555);
    host.wr(BWC_OFF_CAP_PTR, 4'hf, 32'h0);
    rdchk(BWC_OFF_CAP_PTR, 32'h0000_0040);
    host.wr(BWC_OFF_INT_BC, 4'hf, 32'hffff_ffff);
    rdchk(BWC_OFF_INT_BC, 32'h005f_00ff);
    chk({30'h0, prst}, 32'h1, "hot reset on");
    bc(8'h00);
    rdchk(BWC_OFF_INT_BC, 32'h0000_00ff);
    chk({30'h0, prst}, 32'h0, "hot reset off");
    @(posedge sys_clk_i);
    pin_load <= 1'b1;
    pin_value <= 8'h01;
    @(posedge sys_clk_i);
    pin_load <= 1'b0;
    pin_value <= 8'hfe;
    rdchk(BWC_OFF_INT_BC, 32'h0000_01ff);
    $display("test register access done");
    ev(1'b0, 1'b0);
    bc(8'h01);
    ev(1'b1, 1'b0);
    bc(8'h02);
    ev(1'b0, 1'b1);
    $display("test event gating done");
    host.wr(BWC_OFF_PF_BASE_UP, 4'hf, 32'h1);
    host.wr(BWC_OFF_PF_LIM_UP, 4'hf, 32'h1);
    look(1'b0, 64'h1_000f_ffff, 1'b0, 1'b0);
    look(1'b0, 64'h1_0010_0000, 1'b1, 1'b0);
    look(1'b0, 64'h1_002f_ffff, 1'b1, 1'b0);
    look(1'b0, 64'h1_0030_0000, 1'b0, 1'b0);
    look(1'b0, 64'h0_0010_0000, 1'b0, 1'b0);
    bc(8'h08);
    look(1'b0, BWC_VGA_MEM_LO, 1'b1, 1'b0);
    look(1'b0, BWC_VGA_MEM_HI, 1'b1, 1'b0);
    look(1'b0, BWC_VGA_MEM_HI + 64'h1, 1'b0, 1'b0);
    bc(8'h00);
    look(1'b0, BWC_VGA_MEM_LO, 1'b0, 1'b0);
    $display("test memory windows done");
    host.wr(BWC_OFF_IO_UP, 4'hf, 32'h0);
    look(1'b1, 64'h0fff, 1'b0, 1'b0);
    look(1'b1, 64'h1000, 1'b1, 1'b0);
    look(1'b1, 64'h2fff, 1'b1, 1'b0);
    look(1'b1, 64'h3000, 1'b0, 1'b0);
    bc(8'h04);
    look(1'b1, 64'h13ff, 1'b0, 1'b1);
    look(1'b1, 64'h10ff, 1'b1, 1'b0);
    bc(8'h08);
    // 10-bit decode: aliases below 64K hit, above do not
    foreach (vt[i]) look(1'b1, {44'h0, vt[i][19:0]}, vt[i][20], 1'b0);
    bc(8'h18);
    look(1'b1, 64'h43b0, 1'b0, 1'b0);
    look(1'b1, 64'h03c0, 1'b1, 1'b0);
    $display("test io windows done");
    summarize();
  end
endmodule
`default_nettype wire
